// ==== rtl/fpec_map.svh ====
// offsets, field positions, command codes and timing counts of the flash sequencer
`ifndef FPEC_MAP_SVH
`define FPEC_MAP_SVH
`define FPEC_ADDR_W 19
`define FPEC_ROW_HI 18
`define FPEC_ROW_LO 11
`define FPEC_COL_W 11
`define FPEC_SECT_HI 18
`define FPEC_SECT_LO 16
`define FPEC_BOOT_SECT 3'h7
`define FPEC_ID_ADDR 19'h7fff2
`define FPEC_UNLOCK1_ADDR 16'h5555
`define FPEC_UNLOCK2_ADDR 16'h2aaa
`define FPEC_CMD_AA 8'haa
`define FPEC_CMD_55 8'h55
`define FPEC_CMD_SETUP 8'h80
`define FPEC_CMD_ERASE 8'h30
`define FPEC_CMD_PROG 8'ha0
`define FPEC_CMD_ID_IN 8'h90
`define FPEC_CMD_ID_OUT 8'hf0
`define FPEC_BIT_POLL 7
`define FPEC_BIT_TOGGLE 6
`define FPEC_BIT_TIMEOUT 5
`define FPEC_BIT_PROTECT 3
`define FPEC_BIT_BOOTLOCK 2
`define FPEC_CLK_NS 5
`define FPEC_GLITCH_NS 5
`define FPEC_GLITCH_CYC ((`FPEC_GLITCH_NS + `FPEC_CLK_NS - 1) / `FPEC_CLK_NS)
`define FPEC_PROG_US 12
`define FPEC_PROG_CYC (`FPEC_PROG_US * 1000 / `FPEC_CLK_NS)
`define FPEC_ERASE_MS 600
`define FPEC_ERASE_CYC (`FPEC_ERASE_MS * 1000000 / `FPEC_CLK_NS)
`define FPEC_ERASE_ROW_CYC 2
`endif

// ==== rtl/fpec_pkg.sv ====
// types shared by the flash sequencer files
package fpec_pkg;
    typedef enum logic [3:0] {
        FPEC_IDLE = 4'h0,
        FPEC_U1 = 4'h1,
        FPEC_U2 = 4'h2,
        FPEC_SETUP = 4'h3,
        FPEC_U4 = 4'h4,
        FPEC_U5 = 4'h5,
        FPEC_PDATA = 4'h6,
        FPEC_PROG = 4'h7,
        FPEC_ERASE = 4'h8,
        FPEC_FAIL = 4'h9
    } fpec_state_t;
endpackage : fpec_pkg

// ==== rtl/fpec_array.sv ====
// flash cell array: registered read, bitwise-clear program, word-wise erase
`timescale 1ns/1ps
`default_nettype none
`include "fpec_map.svh"
module fpec_array (
    input wire logic i_core_clk, // core clock
    input wire logic [18:0] i_addr, // read or program address
    output logic [7:0] o_rdata, // registered read data
    input wire logic i_prog, // program strobe
    input wire logic [7:0] i_wdata, // program data
    input wire logic i_erase, // erase strobe, one word
    input wire logic [18:0] i_eaddr // erase word address
);
    logic [7:0] mem [0:(1<<19)-1];
    ////////////////////////////////////////////////////////////////////////////
    // program only clears bits; erase sets a word back to ones
    always_ff @(posedge i_core_clk)
    begin
        if (i_prog)
        begin
            mem[i_addr] <= mem[i_addr] & i_wdata; // RL15
        end
        if (i_erase)
        begin
            mem[i_eaddr] <= 8'hff;
        end
        o_rdata <= mem[i_addr];
    end
endmodule : fpec_array
`default_nettype wire

// ==== rtl/fpec_we_filter.sv ====
// write-enable glitch filter: reports a rising edge only after a long enough low
`timescale 1ns/1ps
`default_nettype none
`include "fpec_map.svh"
module fpec_we_filter (
    input wire logic i_core_clk, // core clock
    input wire logic i_rst_n, // sync reset, active low
    input wire logic i_we_n, // write enable pin
    output logic o_we_rise // one-cycle pulse at a valid rising edge
);
    logic [3:0] low_cnt;
    logic we_q;
    // two low samples in a row prove the pulse spanned a full period; one could be a glitch
    wire long_enough = low_cnt > 4'(`FPEC_GLITCH_CYC);
    ////////////////////////////////////////////////////////////////////////////
    // short low pulses never reach the count, so they are dropped
    always_ff @(posedge i_core_clk)
    begin
        if (!i_rst_n)
        begin
            low_cnt <= 4'h0;
            we_q <= 1'b1;
            o_we_rise <= 1'b0;
        end
        else
        begin
            we_q <= i_we_n;
            o_we_rise <= i_we_n && !we_q && long_enough; // RL18
            if (i_we_n)
                low_cnt <= 4'h0;
            else if (!long_enough)
                low_cnt <= low_cnt + 4'h1;
        end
    end
    a_glitch_drop: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
        (o_we_rise |-> $past(we_q, 1) == 1'b0 && $past(we_q, 2) == 1'b0)) // RL18
        else $error("write rise without a full low pulse");
endmodule : fpec_we_filter
`default_nettype wire

// ==== rtl/fpec_sequencer.sv ====
// flash program/erase command sequencer, programmer-side pins
`timescale 1ns/1ps
`default_nettype none
`include "fpec_map.svh"
// Contract
// RL1: mode pin high selects programmer interface, low selects hub; set before reset release.
// RL2: row address forms bits 18:11, column address bits 10:0.
// RL3: data pins driven only while output enable low.
// RL4: hub mode read or write decided by start-cycle bits 0 and 1.
// RL5: reset low halts device and floats outputs; release resumes read.
// RL6: boot-lock low at power-on refuses boot sector program and erase.
// RL7: write-protect low at power-on refuses other sectors.
// RL8: identification read at 7fff2 returns inverted lock and protect levels.
// RL9: three-byte or single-byte exit returns to array reads.
// RL10: sector erase is exactly six ordered write cycles.
// RL11: sector address latched on row/column rise, 30h on write-enable rise.
// RL12: erase only addressed sector, timed internally.
// RL13: erase starts at final write rise; poll bit then one, back to read.
// RL14: host polls erase status inside the erased sector.
// RL15: programming never sets a cell bit.
// RL16: program starts right after the fourth command byte.
// RL17: internal program timer ends after about 12 us, then read mode.
// RL18: write-enable lows shorter than 5 ns are ignored.
// RL19: writes blocked while output enable low or write enable high.
// RL20: status on timeout, toggle and poll bits during operations.
// RL21: programmer mode drives a ready/busy pin.
// RL22: poll bit reads zero while erasing, one when done.
// RL23: toggle bit flips each read while busy, stops when done.
// RL24: timeout bit reads one on failure; host then issues reset command.
// RL25: ready/busy low while busy, released high otherwise.
// RL26: broken write sequences are discarded; device stays in read mode.
module fpec_sequencer #(
    parameter int unsigned PROG_CYC = `FPEC_PROG_CYC, // program time in cycles
    parameter int unsigned ERASE_CYC = `FPEC_ERASE_CYC // erase time in cycles
) (
    input wire logic i_core_clk, // 200 MHz core clock
    input wire logic i_rst_n, // sync reset, active low
    input wire logic i_interface_select_pin, // high: programmer interface
    input wire logic i_top_boot_lock_n, // boot block lock strap
    input wire logic i_write_protect_n, // other-sector protect strap
    input wire logic i_row_col_sel, // high: row address phase
    input wire logic [10:0] i_addr, // multiplexed address pins
    input wire logic i_oe_n, // output enable, active low
    input wire logic i_we_n, // write enable, active low
    input wire logic [7:0] i_dq, // data pins, input side
    output logic [7:0] o_dq, // data pins, output side
    output logic o_dq_oe, // high while driving data pins
    output logic o_ready_busy_out, // open-drain level, low busy
    output logic o_ready_busy_oe, // high while pulling ready/busy low
    input wire logic [1:0] i_hub_start_bits, // hub start-cycle bits 1:0
    output logic o_hub_is_write, // decoded hub transfer direction
    output logic o_hub_mode // latched hub mode
);
    fpec_pkg::fpec_state_t state, next_state;
    logic prog_mode, boot_lock, wr_prot, id_mode, toggle, timeout, row_q, oe_q;
    logic [7:0] row_addr, cmd_data;
    logic [18:0] op_addr;
    logic [31:0] timer;
    logic [15:0] erow;
    logic we_rise;
    logic [7:0] rdata;
    ////////////////////////////////////////////////////////////////////////////
    // decode helpers
    function automatic logic is_cmd(input logic [18:0] a, input logic [7:0] d,
        input logic [15:0] ua, input logic [7:0] ud);
        is_cmd = (a[15:0] == ua) && (d == ud);
    endfunction : is_cmd
    wire [18:0] full_addr = {row_addr, i_addr}; // RL2
    wire [2:0] sect = full_addr[`FPEC_SECT_HI:`FPEC_SECT_LO];
    wire sect_locked = (sect == `FPEC_BOOT_SECT) ? boot_lock : wr_prot; // RL6 RL7
    wire wr_ok = we_rise && i_oe_n && i_rst_n; // RL19
    wire busy = (state == fpec_pkg::FPEC_PROG) || (state == fpec_pkg::FPEC_ERASE);
    wire c_aa = is_cmd(full_addr, cmd_data, `FPEC_UNLOCK1_ADDR, `FPEC_CMD_AA);
    wire c_55 = is_cmd(full_addr, cmd_data, `FPEC_UNLOCK2_ADDR, `FPEC_CMD_55);
    wire c_u3 = full_addr[15:0] == `FPEC_UNLOCK1_ADDR;
    wire read_start = !i_oe_n && oe_q;
    wire erase_done = busy && (timer == 32'h0) && (state == fpec_pkg::FPEC_ERASE);
    // hub start cycle: bit 1 set with bit 0 clear marks a write (RL4)
    assign o_hub_is_write = i_hub_start_bits[1] && !i_hub_start_bits[0]; // RL4
    ////////////////////////////////////////////////////////////////////////////
    fpec_we_filter u_wef (
        .i_core_clk(i_core_clk),
        .i_rst_n(i_rst_n),
        .i_we_n(i_we_n),
        .o_we_rise(we_rise)
    );
    fpec_array u_arr (
        .i_core_clk(i_core_clk),
        .i_addr(busy ? op_addr : full_addr),
        .o_rdata(rdata),
        .i_prog(state == fpec_pkg::FPEC_PROG && timer == 32'h1),
        .i_wdata(cmd_data),
        .i_erase(state == fpec_pkg::FPEC_ERASE),
        .i_eaddr({op_addr[18:16], erow})
    );
    ////////////////////////////////////////////////////////////////////////////
    // straps captured on the first clock after reset release
    always_ff @(posedge i_core_clk)
    begin
        if (!i_rst_n)
        begin
            prog_mode <= 1'b0;
            boot_lock <= 1'b0;
            wr_prot <= 1'b0;
            o_hub_mode <= 1'b0;
        end
        else if (!row_q && !prog_mode && !o_hub_mode)
        begin
            prog_mode <= i_interface_select_pin; // RL1
            o_hub_mode <= !i_interface_select_pin; // RL1
            boot_lock <= !i_top_boot_lock_n; // RL6
            wr_prot <= !i_write_protect_n; // RL7
        end
    end
    ////////////////////////////////////////////////////////////////////////////
    // row latch on row/column falling into column phase, data latch on write
    always_ff @(posedge i_core_clk)
    begin
        if (!i_rst_n)
        begin
            row_q <= 1'b0;
            row_addr <= 8'h00;
            cmd_data <= 8'h00;
            oe_q <= 1'b1;
        end
        else
        begin
            row_q <= 1'b1;
            oe_q <= i_oe_n;
            if (i_row_col_sel)
                row_addr <= i_addr[7:0]; // RL11
            if (!i_we_n && !busy)
                cmd_data <= i_dq; // RL11
        end
    end
    ////////////////////////////////////////////////////////////////////////////
    // command sequence decoder
    always_comb
    begin
        next_state = state;
        case (state)
            fpec_pkg::FPEC_IDLE: if (wr_ok) next_state = c_aa ? fpec_pkg::FPEC_U1 : state;
            fpec_pkg::FPEC_U1: if (wr_ok) next_state = c_55 ? fpec_pkg::FPEC_U2
                : fpec_pkg::FPEC_IDLE; // RL26
            fpec_pkg::FPEC_U2:
                if (wr_ok)
                begin
                    if (c_u3 && cmd_data == `FPEC_CMD_SETUP)
                        next_state = fpec_pkg::FPEC_SETUP; // RL10
                    else if (c_u3 && cmd_data == `FPEC_CMD_PROG)
                        next_state = fpec_pkg::FPEC_PDATA; // RL16
                    else
                        next_state = fpec_pkg::FPEC_IDLE; // RL26
                end
            fpec_pkg::FPEC_SETUP: if (wr_ok) next_state = c_aa ? fpec_pkg::FPEC_U4
                : fpec_pkg::FPEC_IDLE; // RL10
            fpec_pkg::FPEC_U4: if (wr_ok) next_state = c_55 ? fpec_pkg::FPEC_U5
                : fpec_pkg::FPEC_IDLE; // RL10
            fpec_pkg::FPEC_U5:
                if (wr_ok)
                    next_state = (cmd_data == `FPEC_CMD_ERASE && !sect_locked)
                        ? fpec_pkg::FPEC_ERASE : fpec_pkg::FPEC_IDLE; // RL10 RL13
            fpec_pkg::FPEC_PDATA:
                if (wr_ok)
                    next_state = sect_locked ? fpec_pkg::FPEC_IDLE
                        : fpec_pkg::FPEC_PROG; // RL16
            fpec_pkg::FPEC_PROG:
                if (timer == 32'h1)
                    next_state = ((cmd_data & ~rdata) != 8'h00) ? fpec_pkg::FPEC_FAIL
                        : fpec_pkg::FPEC_IDLE; // RL17 RL24
            fpec_pkg::FPEC_ERASE: if (timer == 32'h0) next_state = fpec_pkg::FPEC_IDLE;
            fpec_pkg::FPEC_FAIL:
                if (wr_ok && cmd_data == `FPEC_CMD_ID_OUT)
                    next_state = fpec_pkg::FPEC_IDLE; // RL24
            default: next_state = fpec_pkg::FPEC_IDLE;
        endcase
    end
    ////////////////////////////////////////////////////////////////////////////
    // state, timers, identification mode and toggle bit
    always_ff @(posedge i_core_clk)
    begin
        if (!i_rst_n)
        begin
            state <= fpec_pkg::FPEC_IDLE;
            timer <= 32'h0;
            erow <= 16'h0;
            op_addr <= 19'h0;
            id_mode <= 1'b0;
            toggle <= 1'b0;
            timeout <= 1'b0;
        end
        else
        begin
            state <= next_state;
            if (state == fpec_pkg::FPEC_PDATA && next_state == fpec_pkg::FPEC_PROG)
            begin
                timer <= PROG_CYC; // RL16 RL17
                op_addr <= full_addr;
            end
            else if (state == fpec_pkg::FPEC_U5 && next_state == fpec_pkg::FPEC_ERASE)
            begin
                timer <= ERASE_CYC; // RL12 RL13
                op_addr <= full_addr;
                erow <= 16'h0;
            end
            else if (timer != 32'h0)
            begin
                timer <= timer - 32'h1;
                erow <= erow + 16'h1; // RL12
            end
            if (state == fpec_pkg::FPEC_U2 && wr_ok && c_u3 && cmd_data == `FPEC_CMD_ID_IN)
                id_mode <= 1'b1; // RL8
            else if (wr_ok && cmd_data == `FPEC_CMD_ID_OUT)
                id_mode <= 1'b0; // RL9
            else if (state == fpec_pkg::FPEC_U2 && wr_ok && c_u3 &&
                cmd_data == `FPEC_CMD_ID_OUT)
                id_mode <= 1'b0; // RL9
            if (busy && read_start)
                toggle <= !toggle; // RL23
            timeout <= next_state == fpec_pkg::FPEC_FAIL; // RL24
        end
    end
    ////////////////////////////////////////////////////////////////////////////
    // data pin drive: status while busy or timed out, id bits, else array data
    always_ff @(posedge i_core_clk)
    begin
        if (!i_rst_n)
            o_dq <= 8'h00;
        else if (busy || timeout)
            o_dq <= {busy ? (state == fpec_pkg::FPEC_ERASE ? 1'b0 : ~cmd_data[7]) : 1'b0,
                toggle, timeout, 5'h00}; // RL20 RL22 RL23 RL24
        else if (id_mode && full_addr == `FPEC_ID_ADDR)
            o_dq <= {4'h0, wr_prot, boot_lock, 2'h0}; // RL8
        else
            o_dq <= rdata;
    end
    assign o_dq_oe = i_rst_n && prog_mode && !i_oe_n; // RL3 RL5
    assign o_ready_busy_oe = i_rst_n && prog_mode && busy; // RL21 RL25
    assign o_ready_busy_out = 1'b0;
    ////////////////////////////////////////////////////////////////////////////
    a_bus_float: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
        i_oe_n |-> !o_dq_oe) // RL3
        else $error("data driven with output enable high");
    a_erase_start: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
        (state == fpec_pkg::FPEC_U5 && wr_ok && cmd_data == `FPEC_CMD_ERASE &&
        !sect_locked) |=> state == fpec_pkg::FPEC_ERASE) // RL13
        else $error("erase did not start");
    a_erase_poll: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
        state == fpec_pkg::FPEC_ERASE |=> !o_dq[`FPEC_BIT_POLL]) // RL22
        else $error("poll bit high while erasing");
    a_busy_pin: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
        (prog_mode && busy) |-> o_ready_busy_oe) // RL25
        else $error("ready/busy not low while busy");
    a_locked_sect: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
        (state == fpec_pkg::FPEC_PDATA && wr_ok && sect_locked)
        |=> state == fpec_pkg::FPEC_IDLE) // RL6
        else $error("program reached a locked sector");
    a_write_inhib: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
        (!i_oe_n && state == fpec_pkg::FPEC_IDLE) |=> state == fpec_pkg::FPEC_IDLE) // RL19
        else $error("write accepted with output enable low");
    a_toggle_read: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
        (busy && read_start) |=> toggle != $past(toggle)) // RL23
        else $error("toggle bit did not flip");
    a_seq_abort: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
        (state == fpec_pkg::FPEC_U1 && wr_ok && !c_55) |=> state == fpec_pkg::FPEC_IDLE) // RL26
        else $error("broken sequence not discarded");
    a_erase_end: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
        erase_done |=> state == fpec_pkg::FPEC_IDLE) // RL13
        else $error("erase did not return to read");
endmodule : fpec_sequencer
`default_nettype wire

// ==== test/fpec_host_model.sv ====
// host programmer model driving the programmer-side pins of the flash sequencer
`timescale 1ns/1ps
`default_nettype none
module fpec_host_model (
    input wire logic i_core_clk, // core clock
    input wire logic [7:0] i_bus, // data pins as the host sees them
    input wire logic i_dev_drive, // device drives the data pins
    output logic o_row_col_sel, // high: row phase
    output logic o_addr_unused, // spare, held low
    output logic [10:0] o_addr, // multiplexed address pins
    output logic o_oe_n, // output enable, active low
    output logic o_we_n, // write enable, active low
    output logic [7:0] o_dq // write data
);
    // idle pin levels from time zero
    initial
    begin
        o_row_col_sel = 1'b0;
        o_addr_unused = 1'b0;
        o_addr = 11'h000;
        o_oe_n = 1'b1;
        o_we_n = 1'b1;
        o_dq = 8'h00;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // row phase first so the sector is latched when row/col falls back
    task automatic put_addr(input logic [18:0] a);
        o_row_col_sel = 1'b1;
        o_addr = {3'h0, a[18:11]};
        @(posedge i_core_clk);
        #1;
        o_row_col_sel = 1'b0;
        o_addr = a[10:0];
    endtask : put_addr

    // mode 0 plain write, 1 with output enable held low, 2 a sub-cycle glitch
    task automatic wr(input logic [18:0] a, input logic [7:0] d, input logic [1:0] mode);
        @(posedge i_core_clk);
        #1;
        put_addr(a);
        o_dq = d;
        o_oe_n = (mode == 2'h1) ? 1'b0 : 1'b1;
        o_we_n = (mode == 2'h2) ? 1'b1 : 1'b0;
        if (mode == 2'h2)
        begin
            // a 3 ns low that straddles one clock edge, so it is sampled once
            #2;
            o_we_n = 1'b0;
            #3;
            o_we_n = 1'b1;
        end
        else
        begin
            repeat (2) @(posedge i_core_clk);
            #1;
            o_we_n = 1'b1;
        end
        repeat (3) @(posedge i_core_clk);
        #1;
        o_oe_n = 1'b1;
        o_dq = ~d; // no stale value left on the lines
    endtask : wr

    // read data is registered, so it is settled three edges after the address
    task automatic rd(input logic [18:0] a, output logic [7:0] d, output logic drv);
        @(posedge i_core_clk);
        #1;
        put_addr(a);
        o_oe_n = 1'b0;
        repeat (3) @(posedge i_core_clk);
        #1;
        d = i_bus;
        drv = i_dev_drive;
        o_oe_n = 1'b1;
    endtask : rd
endmodule : fpec_host_model
`default_nettype wire

// ==== test/tb.sv ====
// self-checking bench for the flash sequencer with a host model on its pins
`timescale 1ns/1ps
`default_nettype none
module tb;
    localparam int unsigned PROG_CYC = 20;
    logic i_core_clk = 1'b0;
    logic i_rst_n = 1'b0;
    logic i_interface_select_pin = 1'b1;
    logic i_top_boot_lock_n = 1'b1;
    logic i_write_protect_n = 1'b1;
    logic [1:0] i_hub_start_bits = 2'h0;
    wire logic row_col_sel, oe_n, we_n, dq_oe, rb_oe, rb_out, hub_wr, hub_mode;
    wire logic [10:0] addr;
    wire logic [7:0] host_dq, dev_dq;
    // released device pins show the inverse of the host value, not a stale one
    wire logic [7:0] bus = dq_oe ? dev_dq : ~host_dq;
    wire logic rdy = rb_oe ? rb_out : 1'b1; // pull-up on the open-drain pin
    int failures = 0;
    int total_checks = 0;
    int cyc;
    logic [7:0] rv, d0, d1, s2v;
    logic drv;
    logic [18:0] pa;

    // 200 MHz core clock
    initial
    begin
        forever #2.5 i_core_clk = ~i_core_clk;
    end

    fpec_sequencer #(.PROG_CYC(PROG_CYC), .ERASE_CYC(200)) dut_u (
        .i_core_clk(i_core_clk), .i_rst_n(i_rst_n),
        .i_interface_select_pin(i_interface_select_pin),
        .i_top_boot_lock_n(i_top_boot_lock_n), .i_write_protect_n(i_write_protect_n),
        .i_row_col_sel(row_col_sel), .i_addr(addr), .i_oe_n(oe_n), .i_we_n(we_n),
        .i_dq(host_dq), .o_dq(dev_dq), .o_dq_oe(dq_oe), .o_ready_busy_out(rb_out),
        .o_ready_busy_oe(rb_oe), .i_hub_start_bits(i_hub_start_bits),
        .o_hub_is_write(hub_wr), .o_hub_mode(hub_mode));

    fpec_host_model host_u (
        .i_core_clk(i_core_clk), .i_bus(bus), .i_dev_drive(dq_oe),
        .o_row_col_sel(row_col_sel), .o_addr_unused(), .o_addr(addr),
        .o_oe_n(oe_n), .o_we_n(we_n), .o_dq(host_dq));

    ////////////////////////////////////////////////////////////////////////////////
    task automatic test_done();
        $display("checks %0d failures %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : test_done

    task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
        total_checks++;
        if (seen !== exp)
        begin
            failures++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk

    function automatic logic [7:0] prog_exp(input logic [7:0] old, input logic [7:0] nw);
        return old & nw; // a program only clears bits
    endfunction : prog_exp

    function automatic logic [18:0] sa(input logic [2:0] s, input logic [15:0] o);
        return {s, o};
    endfunction : sa

    task automatic cmd3(input logic [7:0] c);
        host_u.wr(19'h05555, 8'haa, 2'h0);
        host_u.wr(19'h02aaa, 8'h55, 2'h0);
        host_u.wr(19'h05555, c, 2'h0);
    endtask : cmd3

    // full program sequence, every write in the given mode
    task automatic prog(input logic [18:0] a, input logic [7:0] d, input logic [1:0] m);
        host_u.wr(19'h05555, 8'haa, m);
        host_u.wr(19'h02aaa, 8'h55, m);
        host_u.wr(19'h05555, 8'ha0, m);
        host_u.wr(a, d, m);
    endtask : prog

    task automatic erase(input logic [2:0] s);
        cmd3(8'h80);
        host_u.wr(19'h05555, 8'haa, 2'h0);
        host_u.wr(19'h02aaa, 8'h55, 2'h0);
        host_u.wr(sa(s, 16'h0000), 8'h30, 2'h0);
    endtask : erase

    task automatic wait_idle(output int n);
        n = 0;
        while (rb_oe === 1'b1)
        begin
            @(posedge i_core_clk);
            #1;
            n++;
            if (n > 5000)
            begin
                failures++;
                test_done();
            end
        end
    endtask : wait_idle

    // straps settle before release; outputs must float while held
    task automatic rst(input logic tbl, input logic wp);
        @(posedge i_core_clk);
        #1;
        i_rst_n = 1'b0;
        i_top_boot_lock_n = tbl;
        i_write_protect_n = wp;
        host_u.rd(sa(3'h0, 16'h0000), rv, drv);
        chk("float_dq", {7'h0, drv}, 8'h00);
        chk("float_rb", {7'h0, rb_oe}, 8'h00);
        repeat (2) @(posedge i_core_clk);
        #1;
        i_rst_n = 1'b1;
        repeat (3) @(posedge i_core_clk);
        #1;
    endtask : rst

    ////////////////////////////////////////////////////////////////////////////////
    // main sequence
    initial
    begin
        void'($urandom(82208));
        rst(1'b1, 1'b1);
        for (int k = 0; k < 4; k++)
        begin
            @(posedge i_core_clk);
            #1;
            i_hub_start_bits = k[1:0];
            #1;
            chk("hub_dir", {7'h0, hub_wr}, (k == 2) ? 8'h01 : 8'h00);
        end
        chk("hub_mode", {7'h0, hub_mode}, 8'h00);
        erase(3'h2);
        wait_idle(cyc);
        s2v = 8'($urandom) & 8'h7f;
        prog(sa(3'h2, 16'h0005), s2v, 2'h0);
        wait_idle(cyc);
        erase(3'h1);
        chk("erase_busy", {7'h0, rdy}, 8'h00);
        host_u.rd(sa(3'h1, 16'h0009), rv, drv);
        chk("poll_erase", {7'h0, rv[7]}, 8'h00);
        host_u.rd(sa(3'h1, 16'h0009), d1, drv);
        chk("toggle", {7'h0, rv[6] ^ d1[6]}, 8'h01);
        wait_idle(cyc);
        host_u.rd(sa(3'h1, 16'h0009), rv, drv);
        chk("erased", rv, 8'hff);
        host_u.rd(sa(3'h1, 16'h0009), d1, drv);
        chk("settled", d1, 8'hff);
        host_u.rd(sa(3'h2, 16'h0005), rv, drv);
        chk("other_sector", rv, s2v);
        chk("drive_oe_low", {7'h0, drv}, 8'h01);
        #1;
        chk("float_oe_high", {7'h0, dq_oe}, 8'h00);
        for (int i = 0; i < 4; i++)
        begin
            pa = sa(3'h1, 16'(i * 8 + $urandom_range(7)));
            d1 = 8'($urandom);
            prog(pa, d1, 2'h0);
            chk("prog_busy", {7'h0, rb_oe}, 8'h01);
            wait_idle(cyc);
            chk("prog_time", {7'h0, cyc + 4 >= PROG_CYC && cyc <= PROG_CYC + 4}, 8'h01);
            host_u.rd(pa, rv, drv);
            chk("prog_data", rv, prog_exp(8'hff, d1));
        end
        d0 = d1 & 8'($urandom) & 8'hfe;
        prog(pa, d0, 2'h0);
        wait_idle(cyc);
        host_u.rd(pa, rv, drv);
        chk("clear_only", rv, prog_exp(d1, d0));
        d1 = d0;
        // a program that would set a bit must end in the over-time status
        prog(pa, 8'hff, 2'h0);
        cyc = 0;
        rv = 8'h00;
        while (rv[5] !== 1'b1 && cyc < 100)
        begin
            host_u.rd(pa, rv, drv);
            cyc++;
        end
        chk("over_time", {7'h0, rv[5]}, 8'h01);
        host_u.wr(19'h00000, 8'hf0, 2'h0);
        host_u.rd(pa, rv, drv);
        chk("no_set", rv, d1);
        chk("ready_again", {7'h0, rb_oe}, 8'h00);
        cmd3(8'h90);
        host_u.rd(19'h7fff2, rv, drv);
        chk("id_unlocked", {6'h0, rv[3:2]}, 8'h00);
        cmd3(8'hf0);
        host_u.rd(pa, rv, drv);
        chk("id_exit3", rv, d1);
        cmd3(8'h77);
        host_u.wr(19'h05555, 8'haa, 2'h0);
        host_u.wr(pa, 8'h00, 2'h0);
        host_u.rd(pa, rv, drv);
        chk("bad_seq", rv, d1);
        for (int m = 1; m < 3; m++)
        begin
            prog(pa, 8'h00, 2'(m));
            chk("blocked_busy", {7'h0, rb_oe}, 8'h00);
            host_u.rd(pa, rv, drv);
            chk("blocked_data", rv, d1);
        end
        // second power-on with both straps low
        rst(1'b0, 1'b0);
        prog(sa(3'h2, 16'h0005), 8'h00, 2'h0);
        chk("wp_busy", {7'h0, rb_oe}, 8'h00);
        host_u.rd(sa(3'h2, 16'h0005), rv, drv);
        chk("wp_data", rv, s2v);
        host_u.rd(sa(3'h7, 16'h0003), d0, drv);
        prog(sa(3'h7, 16'h0003), 8'h00, 2'h0);
        chk("boot_busy", {7'h0, rb_oe}, 8'h00);
        host_u.rd(sa(3'h7, 16'h0003), rv, drv);
        chk("boot_data", rv, d0);
        cmd3(8'h90);
        host_u.rd(19'h7fff2, rv, drv);
        chk("id_locked", {6'h0, rv[3:2]}, 8'h03);
        host_u.wr(19'h00000, 8'hf0, 2'h0);
        host_u.rd(sa(3'h2, 16'h0005), rv, drv);
        chk("id_exit1", rv, s2v);
        // third power-on in hub mode: programmer pins must stay released
        i_interface_select_pin = 1'b0;
        rst(1'b1, 1'b1);
        chk("hub_mode_on", {7'h0, hub_mode}, 8'h01);
        host_u.rd(sa(3'h2, 16'h0005), rv, drv);
        chk("hub_no_drive", {7'h0, drv}, 8'h00);
        test_done();
    end
endmodule : tb
`default_nettype wire
